// ==== logic/rhps_port.sv ====
// Root hub port status word with interrupt and hub control registers
`timescale 1ns/10ps
module rhps_port (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [rhps_pkg::ADDR_W-1:0] addr,
	input wire logic [rhps_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	output logic [rhps_pkg::DATA_W-1:0] rd_data,
	input wire logic line_attach,
	input wire logic line_low_speed,
	output logic port_supply_on,
	output logic irq
);

	//------------------------------------------------------------------
	// Decode helper
	//------------------------------------------------------------------
	// Strobe qualified register select
	function automatic logic hit(
		input logic strobe,
		input logic [rhps_pkg::ADDR_W-1:0] a,
		input logic [rhps_pkg::ADDR_W-1:0] off
	);
		hit = strobe && (a == off);
	endfunction : hit

	//------------------------------------------------------------------
	// Declarations
	//------------------------------------------------------------------
	logic wr_port;
	logic wr_istat;
	logic wr_imask;
	logic wr_hub;
	logic cmd_supply_on;
	logic cmd_supply_drop;
	logic cmd_enable;
	logic cmd_suspend;
	logic cmd_reset;
	logic clr_attach_chg;
	logic clr_enable_chg;
	logic hub_reset_cmd;
	logic port_clr;
	logic attach_present;
	logic slow_device_flag;
	logic attach_event;
	logic removable_mask;
	logic report_pend;
	logic attach_change_flag;
	logic enable_change_flag;
	logic set_attach_chg;
	logic set_enable_chg;
	logic stray_request;
	logic edge_report;
	logic boot_report;
	logic enable_lost;
	rhps_pkg::rhps_port_e port_state;
	rhps_pkg::rhps_port_e next_port_state;
	logic [rhps_pkg::INT_N-1:0] int_status;
	logic [rhps_pkg::INT_N-1:0] int_mask;
	logic [rhps_pkg::INT_N-1:0] int_event;
	logic [rhps_pkg::DATA_W-1:0] port_word;
	logic [rhps_pkg::DATA_W-1:0] next_rd_data;

	//------------------------------------------------------------------
	// Write decode
	//------------------------------------------------------------------
	// Register selects
	assign wr_port = hit(wr_en, addr, rhps_pkg::OFF_PORT);
	assign wr_istat = hit(wr_en, addr, rhps_pkg::OFF_ISTAT);
	assign wr_imask = hit(wr_en, addr, rhps_pkg::OFF_IMASK);
	assign wr_hub = hit(wr_en, addr, rhps_pkg::OFF_HUB);

	// Port word writes are one-shot commands, never stored values
	assign cmd_supply_on = wr_port && wr_data[rhps_pkg::B_SUPPLY];
	assign cmd_supply_drop = wr_port && wr_data[rhps_pkg::B_SLOW];
	assign cmd_enable = wr_port && wr_data[rhps_pkg::B_ENABLE];
	assign cmd_suspend = wr_port && wr_data[rhps_pkg::B_SUSPEND];
	assign cmd_reset = wr_port && wr_data[rhps_pkg::B_RESET];
	assign clr_attach_chg = wr_port && wr_data[rhps_pkg::B_ATTACH_CHG];
	assign clr_enable_chg = wr_port && wr_data[rhps_pkg::B_ENABLE_CHG];
	assign hub_reset_cmd = wr_hub && wr_data[rhps_pkg::B_HUB_RESET];

	// A hub reset clears the whole port back to its reset picture
	assign port_clr = hub_reset_cmd;

	//------------------------------------------------------------------
	// Attach detection
	//------------------------------------------------------------------
	rhps_attach_det u_attach (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.port_clr(port_clr),
		.powered(port_supply_on),
		.line_attach(line_attach),
		.line_low_speed(line_low_speed),
		.attach_present(attach_present),
		.slow_device_flag(slow_device_flag),
		.attach_event(attach_event)
	);

	//------------------------------------------------------------------
	// Port power
	//------------------------------------------------------------------
	// Drop beats turn-on when both bits are written: the safe side
	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			port_supply_on <= 1'b0;
		end else if (cmd_supply_drop) begin
			port_supply_on <= 1'b0;
		end else if (cmd_supply_on) begin
			port_supply_on <= 1'b1;
		end
	end

	//------------------------------------------------------------------
	// Hub control
	//------------------------------------------------------------------
	// Set bit marks the attached device as non-removable
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			removable_mask <= 1'b0;
		end else if (wr_hub) begin
			removable_mask <= wr_data[rhps_pkg::B_NONREM];
		end
	end

	// Pending report armed by any hub reset, spent on first attach
	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			report_pend <= 1'b1;
		end else if (attach_present) begin
			report_pend <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// Attach change flag
	//------------------------------------------------------------------
	// Requests to a detached port make the driver look again
	assign stray_request = (cmd_enable || cmd_suspend || cmd_reset) && !attach_present;

	// Non-removable devices only report once, after a hub reset
	assign edge_report = attach_event && !removable_mask;
	assign boot_report = report_pend && attach_present && removable_mask;
	assign set_attach_chg = edge_report || boot_report || stray_request;

	// Set wins over a clear in the same cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			attach_change_flag <= 1'b0;
		end else if (set_attach_chg) begin
			attach_change_flag <= 1'b1;
		end else if (clr_attach_chg) begin
			attach_change_flag <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// Port enable state
	//------------------------------------------------------------------
	// Requests only take effect on an attached port
	always_comb begin
		next_port_state = port_state;
		case (port_state)
			rhps_pkg::RHPS_DISABLED: begin
				if (attach_present && (cmd_enable || cmd_reset)) begin
					next_port_state = rhps_pkg::RHPS_ENABLED;
				end
			end
			rhps_pkg::RHPS_ENABLED: begin
				if (!attach_present) begin
					next_port_state = rhps_pkg::RHPS_DISABLED;
				end else if (cmd_suspend) begin
					next_port_state = rhps_pkg::RHPS_SUSPENDED;
				end
			end
			rhps_pkg::RHPS_SUSPENDED: begin
				if (!attach_present) begin
					next_port_state = rhps_pkg::RHPS_DISABLED;
				end else if (cmd_reset) begin
					next_port_state = rhps_pkg::RHPS_ENABLED;
				end
			end
			default: begin
				next_port_state = rhps_pkg::RHPS_DISABLED;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			port_state <= rhps_pkg::RHPS_DISABLED;
		end else begin
			port_state <= next_port_state;
		end
	end

	// Only hardware loss of enable counts, never a software write
	assign enable_lost = (port_state != rhps_pkg::RHPS_DISABLED) &&
		(next_port_state == rhps_pkg::RHPS_DISABLED);
	assign set_enable_chg = enable_lost;

	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			enable_change_flag <= 1'b0;
		end else if (set_enable_chg) begin
			enable_change_flag <= 1'b1;
		end else if (clr_enable_chg) begin
			enable_change_flag <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// Interrupts
	//------------------------------------------------------------------
	// Events are the flag set conditions, one pulse each
	assign int_event[rhps_pkg::I_ATTACH] = set_attach_chg;
	assign int_event[rhps_pkg::I_ENABLE] = set_enable_chg;

	// Sticky bits, write one to clear, set wins
	generate
		for (genvar i = 0; i < rhps_pkg::INT_N; i++) begin : g_int
			always_ff @(posedge ref_clk) begin
				if (!rst_n) begin
					int_status[i] <= 1'b0;
				end else if (int_event[i]) begin
					int_status[i] <= 1'b1;
				end else if (wr_istat && wr_data[i]) begin
					int_status[i] <= 1'b0;
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			int_mask <= rhps_pkg::INT_RST;
		end else if (wr_imask) begin
			int_mask <= wr_data[rhps_pkg::INT_N-1:0];
		end
	end

	// Level output, one cycle behind the status bits
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			irq <= 1'b0;
		end else begin
			irq <= |(int_status & int_mask);
		end
	end

	//------------------------------------------------------------------
	// Read path
	//------------------------------------------------------------------
	// Shared positions return status; reset status is never held
	always_comb begin
		port_word = rhps_pkg::WORD_ZERO;
		port_word[rhps_pkg::B_ATTACH] = attach_present;
		port_word[rhps_pkg::B_ENABLE] = (port_state == rhps_pkg::RHPS_ENABLED) ||
			(port_state == rhps_pkg::RHPS_SUSPENDED);
		port_word[rhps_pkg::B_SUSPEND] = (port_state == rhps_pkg::RHPS_SUSPENDED);
		port_word[rhps_pkg::B_SUPPLY] = port_supply_on;
		port_word[rhps_pkg::B_SLOW] = slow_device_flag;
		port_word[rhps_pkg::B_ATTACH_CHG] = attach_change_flag;
		port_word[rhps_pkg::B_ENABLE_CHG] = enable_change_flag;
	end

	// Unmapped offsets and idle cycles read zero
	always_comb begin
		next_rd_data = rhps_pkg::WORD_ZERO;
		if (hit(rd_en, addr, rhps_pkg::OFF_PORT)) begin
			next_rd_data = port_word;
		end else if (hit(rd_en, addr, rhps_pkg::OFF_ISTAT)) begin
			next_rd_data[rhps_pkg::INT_N-1:0] = int_status;
		end else if (hit(rd_en, addr, rhps_pkg::OFF_IMASK)) begin
			next_rd_data[rhps_pkg::INT_N-1:0] = int_mask;
		end else if (hit(rd_en, addr, rhps_pkg::OFF_HUB)) begin
			next_rd_data[rhps_pkg::B_NONREM] = removable_mask;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			rd_data <= rhps_pkg::WORD_ZERO;
		end else begin
			rd_data <= next_rd_data;
		end
	end

endmodule : rhps_port

// ==== logic/rhps_pkg.sv ====
// Constants, offsets and field positions of the root hub port status block
//----------------------------------------------------------------------
// Contract
//----------------------------------------------------------------------
package rhps_pkg;

	// Register bus geometry
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;

	// Register byte offsets
	localparam logic [ADDR_W-1:0] OFF_PORT = 4'h0;
	localparam logic [ADDR_W-1:0] OFF_ISTAT = 4'h4;
	localparam logic [ADDR_W-1:0] OFF_IMASK = 4'h8;
	localparam logic [ADDR_W-1:0] OFF_HUB = 4'hC;

	// Port word: read status / write command
	localparam int B_ATTACH = 0;
	localparam int B_ENABLE = 1;
	localparam int B_SUSPEND = 2;
	localparam int B_RESET = 3;
	localparam int B_SUPPLY = 8;
	localparam int B_SLOW = 9;
	localparam int B_ATTACH_CHG = 16;
	localparam int B_ENABLE_CHG = 17;

	// Hub control word
	localparam int B_NONREM = 0;
	localparam int B_HUB_RESET = 1;

	// Interrupt status and mask layout
	localparam int INT_N = 2;
	localparam int I_ATTACH = 0;
	localparam int I_ENABLE = 1;

	// Reset values
	localparam logic [INT_N-1:0] INT_RST = 2'h0;
	localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;

	// Port enable state
	typedef enum logic [1:0] {
		RHPS_DISABLED = 2'b00,
		RHPS_ENABLED = 2'b01,
		RHPS_SUSPENDED = 2'b10
	} rhps_port_e;

endpackage : rhps_pkg

// ==== logic/rhps_attach_det.sv ====
// Attach detector: power gated line sampling and change events
`timescale 1ns/10ps
module rhps_attach_det (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic port_clr,
	input wire logic powered,
	input wire logic line_attach,
	input wire logic line_low_speed,
	output logic attach_present,
	output logic slow_device_flag,
	output logic attach_event
);

	logic next_attach;

	// Unpowered port never reports a device
	assign next_attach = line_attach & powered;

	//------------------------------------------------------------------
	// Line state
	//------------------------------------------------------------------
	// Present flag and speed follow the line one cycle late
	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			attach_present <= 1'b0;
			slow_device_flag <= 1'b0;
		end else begin
			attach_present <= next_attach;
			slow_device_flag <= next_attach & line_low_speed;
		end
	end

	// One pulse per connect or disconnect
	always_ff @(posedge ref_clk) begin
		if (!rst_n || port_clr) begin
			attach_event <= 1'b0;
		end else begin
			attach_event <= next_attach ^ attach_present;
		end
	end

endmodule : rhps_attach_det

// ==== testbench/rhps_port_assertions.sv ====
// Port level checks of the root hub port status block
`timescale 1ns/10ps
module rhps_port_chk (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [rhps_pkg::ADDR_W-1:0] addr,
	input wire logic [rhps_pkg::DATA_W-1:0] wr_data,
	input wire logic wr_en,
	input wire logic rd_en,
	input wire logic [rhps_pkg::DATA_W-1:0] rd_data,
	input wire logic line_attach,
	input wire logic line_low_speed,
	input wire logic port_supply_on,
	input wire logic irq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Port word accesses
	logic wp;
	logic rp;
	assign wp = wr_en && addr == 4'h0;
	assign rp = rd_en && addr == 4'h0;
	property p_rd_idle; !rd_en |=> rd_data == 32'h0; endproperty
	a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
	property p_on; wp && wr_data[8] && !wr_data[9] |=> port_supply_on; endproperty
	a_on: assert property (p_on) else $error("power on write lost");
	property p_drop; wp && wr_data[9] |=> !port_supply_on; endproperty
	a_drop: assert property (p_drop) else $error("power drop write lost");
	// Only port and hub writes may move the power switch
	property p_hold;
		!(wr_en && (addr == 4'h0 || addr == 4'hC)) |=> $stable(port_supply_on);
	endproperty
	a_hold: assert property (p_hold) else $error("power moved by itself");
	property p_unm; rd_en && addr[1:0] != 2'h0 |=> rd_data == 32'h0; endproperty
	a_unm: assert property (p_unm) else $error("unmapped read not zero");
	property p_hub; rd_en && addr == 4'hC |=> rd_data[31:1] == 31'h0; endproperty
	a_hub: assert property (p_hub) else $error("hub command bit reads back");
	property p_rsv; rp |=> (rd_data & 32'hFFFC_FCF8) == 32'h0; endproperty
	a_rsv: assert property (p_rsv) else $error("unused port bits set");
	property p_slow_det; rp |=> !(rd_data[9] && !rd_data[0]); endproperty
	a_slow_det: assert property (p_slow_det) else $error("speed shown while detached");
	// Settled powered device: attach and speed follow the line
	property p_speed;
		(port_supply_on && line_attach && $stable(line_low_speed))[*3] ##0 rp
		|=> rd_data[0] && rd_data[9] == $past(line_low_speed);
	endproperty
	a_speed: assert property (p_speed) else $error("speed or attach wrong");
	property p_irq; wr_en && addr == 4'h8 && wr_data[1:0] == 2'h0 |=> ##1 !irq; endproperty
	a_irq: assert property (p_irq) else $error("masked interrupt raised");
	c_chg: cover property (rp ##1 rd_data[16]);
	c_drop: cover property (wp && wr_data[9]);
	c_irq: cover property (irq);
endmodule : rhps_port_chk

// ==== testbench/rhps_func_dev.sv ====
// Behavioural USB function device on the downstream port
`timescale 1ns/10ps
module rhps_func_dev (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic powered,
	input wire logic plug,
	input wire logic low,
	output logic line_attach,
	output logic line_low_speed
);
	// No supply, no attach; a detached speed line wanders every cycle
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			line_attach <= 1'b0;
			line_low_speed <= 1'b0;
		end else begin
			line_attach <= plug && powered;
			line_low_speed <= (plug && powered) ? low : !line_low_speed;
		end
	end
endmodule : rhps_func_dev

// ==== testbench/tb.sv ====
// Self-checking bench for the root hub port status block
`timescale 1ns/10ps
module tb;
	logic ref_clk;
	logic rst_n;
	logic [rhps_pkg::ADDR_W-1:0] addr;
	logic [rhps_pkg::DATA_W-1:0] wr_data;
	logic wr_en;
	logic rd_en;
	logic [rhps_pkg::DATA_W-1:0] rd_data;
	logic line_attach;
	logic line_low_speed;
	logic port_supply_on;
	logic irq;
	logic plug;
	logic low;
	int errors;
	int samples_checked;
	int cycles;
	rhps_port u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
		.wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .line_attach(line_attach),
		.line_low_speed(line_low_speed), .port_supply_on(port_supply_on), .irq(irq));
	rhps_func_dev u_dev (.ref_clk(ref_clk), .rst_n(rst_n), .powered(port_supply_on),
		.plug(plug), .low(low), .line_attach(line_attach), .line_low_speed(line_low_speed));
	// Clock
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	// Gap cycle after each strobe keeps a driver from assigning twice
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		addr <= a;
		wr_data <= d;
		wr_en <= 1'b1;
		@(posedge ref_clk);
		wr_en <= 1'b0;
		@(posedge ref_clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [31:0] m, input logic [31:0] exp);
		addr <= a;
		rd_en <= 1'b1;
		@(posedge ref_clk);
		rd_en <= 1'b0;
		#1 chk(rd_data & m, exp);
		@(posedge ref_clk);
	endtask : rd
	task automatic pins(input logic [31:0] exp);
		#1 chk({30'h0, port_supply_on, irq}, exp);
		@(posedge ref_clk);
	endtask : pins
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : give_verdict
	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			errors++;
			give_verdict();
		end
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		addr = 4'h0;
		wr_data = 32'h0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		plug = 1'b0;
		low = 1'b0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		@(posedge ref_clk);
		rd(4'h0, 32'hFFFF_FFFF, 32'h0);
		pins(32'h0);
		// Requests on a detached port, a zero write, then a one write
		for (int i = 1; i < 4; i++) begin
			wr(4'h0, 32'h1 << i);
			rd(4'h0, 32'h0001_0007, 32'h0001_0000);
			wr(4'h0, 32'h0);
			rd(4'h0, 32'h0001_0000, 32'h0001_0000);
			wr(4'h0, 32'h0001_0000);
			rd(4'h0, 32'h0001_0000, 32'h0);
		end
		wr(4'h8, 32'h1);
		pins(32'h1);
		wr(4'h4, 32'h1);
		pins(32'h0);
		wr(4'h0, 32'h0000_0100);
		wr(4'h0, 32'h0);
		pins(32'h2);
		// Low speed, detach, full speed
		plug <= 1'b1;
		low <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd(4'h0, 32'h0001_0301, 32'h0001_0301);
		pins(32'h3);
		wr(4'h0, 32'h0001_0000);
		wr(4'h4, 32'h1);
		plug <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rd(4'h0, 32'h0001_0301, 32'h0001_0100);
		wr(4'h0, 32'h0001_0000);
		low <= 1'b0;
		plug <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd(4'h0, 32'h0001_0301, 32'h0001_0101);
		wr(4'h0, 32'h0000_0200);
		rd(4'h0, 32'h0000_0301, 32'h0);
		// Fixed device reported only after a hub reset
		wr(4'h0, 32'h0001_0000);
		wr(4'hC, 32'h1);
		wr(4'hC, 32'h3);
		wr(4'h0, 32'h0000_0100);
		repeat (6) @(posedge ref_clk);
		rd(4'h0, 32'h0001_0001, 32'h0001_0001);
		wr(4'h0, 32'h0001_0000);
		plug <= 1'b0;
		repeat (6) @(posedge ref_clk);
		plug <= 1'b1;
		repeat (6) @(posedge ref_clk);
		rd(4'h0, 32'h0001_0001, 32'h0000_0001);
		// Enable and suspend requests on an attached port, then loss by unplug
		wr(4'h0, 32'h0000_0002);
		rd(4'h0, 32'h0001_0006, 32'h0000_0002);
		wr(4'h0, 32'h0000_0004);
		rd(4'h0, 32'h0001_0006, 32'h0000_0006);
		plug <= 1'b0;
		repeat (6) @(posedge ref_clk);
		rd(4'h0, 32'h0003_0007, 32'h0002_0000);
		rd(4'hC, 32'hFFFF_FFFF, 32'h1);
		rd(4'h2, 32'hFFFF_FFFF, 32'h0);
		// Masking every source drops the level output two cycles later
		wr(4'h8, 32'h0);
		pins(32'h2);
		give_verdict();
	end
endmodule : tb
bind rhps_port rhps_port_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr),
	.wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
	.line_attach(line_attach), .line_low_speed(line_low_speed),
	.port_supply_on(port_supply_on), .irq(irq));
